/* File: rtl/sfw_pkg.sv */
package sfw_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] ADDR_ST_X     = 8'h50;
  localparam logic [7:0] ADDR_ST_Y     = 8'h51;
  localparam logic [7:0] ADDR_ST_Z     = 8'h52;
  localparam logic [7:0] ADDR_WM_HIGH  = 8'h60;
  localparam logic [7:0] ADDR_WM_LOW   = 8'h61;
  localparam logic [7:0] ADDR_PATH_RST = 8'h68;
  localparam logic [7:0] ADDR_MOTION   = 8'h69;
  localparam logic [7:0] ADDR_HOST     = 8'h6A;

  // Field positions
  localparam int PATH_ACCEL_BIT   = 1;
  localparam int PATH_TEMP_BIT    = 0;
  localparam int MOT_ENABLE_BIT   = 7;
  localparam int MOT_COMPARE_BIT  = 6;
  localparam int MOT_LIMIT_BIT    = 1;
  localparam int MOT_COMBINE_BIT  = 0;
  localparam int HOST_FIFO_EN_BIT = 6;
  localparam int HOST_FIFO_RST_BIT = 2;
  localparam int HOST_ALL_RST_BIT = 0;

  // Values after reset
  localparam logic [7:0] WM_HIGH_RST  = 8'h00;
  localparam logic [7:0] WM_LOW_RST   = 8'h00;
  localparam logic [7:0] MOTION_RST   = 8'h00;
  localparam logic [7:0] HOST_RST     = 8'h00;
  localparam logic [7:0] SELFTEST_CODE_RST  = 8'h00;
  localparam logic [7:0] READ_ZERO    = 8'h00;

  // Interrupt pulse timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int INT_PULSE_NS  = 50;
  localparam int INT_PULSE_CYC =
    (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W   = 4;

  typedef struct packed {
    logic motionDetectEnable;
    logic motionCompareMode;
    logic outputLimitOff;
    logic axisCombineMode;
    logic fifoEnable;
  } sfw_cfg_t;

  typedef struct packed {
    logic gyroPathRst;
    logic accelPathRst;
    logic tempPathRst;
    logic sensorRegClear;
    logic fifoRst;
  } sfw_rst_t;

  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
  } sfw_codes_t;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_FIRST,
    RD_REST
  } sfw_rd_state_t;

endpackage

/* File: rtl/sfw_selftest_store.sv */
`timescale 1ns/1ps
module sfw_selftest_store
  import sfw_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Factory code load
  input  wire logic       otpLoad,
  input  wire sfw_codes_t otpCodes,
  // Host writes
  input  wire logic [2:0] wrSel,
  input  wire logic [7:0] wrData,
  // Stored codes
  output sfw_codes_t      codes
);

  logic [7:0] otpAxis [3];
  logic [7:0] code_r  [3];

  assign otpAxis[0] = otpCodes.x;
  assign otpAxis[1] = otpCodes.y;
  assign otpAxis[2] = otpCodes.z;

  // Codes are loaded after reset release, never under reset
  for (genvar i = 0; i < 3; i++) begin : g_axis
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        code_r[i] <= SELFTEST_CODE_RST;
      end else if (otpLoad) begin
        code_r[i] <= otpAxis[i];
      end else if (wrSel[i]) begin
        code_r[i] <= wrData;
      end
    end
  end

  assign codes = '{x: code_r[0], y: code_r[1], z: code_r[2]};

endmodule

/* File: rtl/sfw_int_pin.sv */
`timescale 1ns/1ps
module sfw_int_pin
  import sfw_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Watermark state
  input  wire logic flagSet,
  input  wire logic flagLevel,
  input  wire logic latchMode,
  // Pin drive
  output logic      intPin
);

  logic [PULSE_CNT_W-1:0] pulseCnt_r;

  // Pulse length counts from the setting edge of the flag
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulseCnt_r <= '0;
    end else if (flagSet && !latchMode) begin
      pulseCnt_r <= PULSE_CNT_W'(INT_PULSE_CYC);
    end else if (pulseCnt_r != '0) begin
      pulseCnt_r <= pulseCnt_r - PULSE_CNT_W'(1);
    end
  end

  // Latch mode follows the flag, so it drops with the flag
  assign intPin = latchMode ? flagLevel : (pulseCnt_r != '0);

endmodule

/* File: rtl/sfw_wm_ctrl_regs.sv */
`timescale 1ns/1ps
module sfw_wm_ctrl_regs
  import sfw_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Serial register port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regRdEn,
  output logic [7:0]       regRdData,
  output logic             regHit,
  // Factory code load
  input  wire logic        otpLoad,
  input  wire sfw_codes_t  otpCodes,
  // FIFO side
  input  wire logic [15:0] fifoCount,
  input  wire logic        fifoBurstActive,
  input  wire logic        fifoDataRead,
  // Interrupt pin setting
  input  wire logic        intLatchMode,
  // Watermark outputs
  output logic             watermarkStatusFlag,
  output logic             watermarkIntPin,
  // Control outputs
  output sfw_cfg_t         cfg,
  output logic             outputLimitEn,
  output sfw_rst_t         pathRst,
  output sfw_codes_t       factoryCodes
);

  // Stored fields
  logic [1:0]    wmHigh_r;
  logic [7:0]    wmLow_r;
  logic          motionEnable_r;
  logic          motionCompare_r;
  logic          outputLimitOff_r;
  logic          axisCombine_r;
  logic          fifoEnable_r;
  sfw_rst_t      pathRst_r;
  logic [7:0]    rdData_r;
  logic          flag_r;
  logic          flag_nxt;
  sfw_rd_state_t rdState_r;
  sfw_rd_state_t rdState_nxt;

  // Decoded accesses
  logic          wrWmHigh;
  logic          wrWmLow;
  logic          wrPath;
  logic          wrMotion;
  logic          wrHost;
  logic [2:0]    wrSelftest;
  logic          mapped;
  logic [7:0]    rdMux;

  // Watermark terms
  logic [9:0]    threshold;
  logic          thrNonZero;
  logic          countAtLevel;
  logic          wmCondition;
  logic          dataRead;
  logic          firstRead;
  logic          wmSet;
  logic          wmClear;

  always_comb begin
    wrWmHigh   = regWrEn && (regAddr == ADDR_WM_HIGH);
    wrWmLow    = regWrEn && (regAddr == ADDR_WM_LOW);
    wrPath     = regWrEn && (regAddr == ADDR_PATH_RST);
    wrMotion   = regWrEn && (regAddr == ADDR_MOTION);
    wrHost     = regWrEn && (regAddr == ADDR_HOST);
    wrSelftest = {regWrEn && (regAddr == ADDR_ST_Z),
                  regWrEn && (regAddr == ADDR_ST_Y),
                  regWrEn && (regAddr == ADDR_ST_X)};
  end

  // Factory self-test codes
  sfw_selftest_store u_selftest (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .otpLoad  (otpLoad),
    .otpCodes (otpCodes),
    .wrSel    (wrSelftest),
    .wrData   (regWrData),
    .codes    (factoryCodes)
  );

  // Threshold registers; unused upper bits of the high byte are dropped
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wmHigh_r <= WM_HIGH_RST[1:0];
      wmLow_r  <= WM_LOW_RST;
    end else begin
      if (wrWmHigh) begin
        wmHigh_r <= regWrData[1:0];
      end
      if (wrWmLow) begin
        wmLow_r <= regWrData;
      end
    end
  end

  // Motion wake control
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      motionEnable_r   <= MOTION_RST[MOT_ENABLE_BIT];
      motionCompare_r  <= MOTION_RST[MOT_COMPARE_BIT];
      outputLimitOff_r <= MOTION_RST[MOT_LIMIT_BIT];
      axisCombine_r    <= MOTION_RST[MOT_COMBINE_BIT];
    end else if (wrMotion) begin
      motionEnable_r   <= regWrData[MOT_ENABLE_BIT];
      // Zero is stored as written; keeping it at one is the host's duty
      motionCompare_r  <= regWrData[MOT_COMPARE_BIT];
      outputLimitOff_r <= regWrData[MOT_LIMIT_BIT];
      axisCombine_r    <= regWrData[MOT_COMBINE_BIT];
    end
  end

  // FIFO enable is the only stored host control bit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fifoEnable_r <= HOST_RST[HOST_FIFO_EN_BIT];
    end else if (wrHost) begin
      fifoEnable_r <= regWrData[HOST_FIFO_EN_BIT];
    end
  end

  // Reset strobes last one cycle and then clear themselves
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pathRst_r <= '0;
    end else begin
      pathRst_r.accelPathRst <=
        (wrPath && regWrData[PATH_ACCEL_BIT]) ||
        (wrHost && regWrData[HOST_ALL_RST_BIT]);
      pathRst_r.tempPathRst <=
        (wrPath && regWrData[PATH_TEMP_BIT]) ||
        (wrHost && regWrData[HOST_ALL_RST_BIT]);
      pathRst_r.gyroPathRst <=
        wrHost && regWrData[HOST_ALL_RST_BIT];
      // Only the full reset clears the sensor output registers
      pathRst_r.sensorRegClear <=
        wrHost && regWrData[HOST_ALL_RST_BIT];
      // The FIFO takes this as an asynchronous reset
      pathRst_r.fifoRst <=
        wrHost && regWrData[HOST_FIFO_RST_BIT];
    end
  end

  assign pathRst = pathRst_r;

  assign cfg = '{motionDetectEnable: motionEnable_r,
                 motionCompareMode:  motionCompare_r,
                 outputLimitOff:     outputLimitOff_r,
                 axisCombineMode:    axisCombine_r,
                 fifoEnable:         fifoEnable_r};

  assign outputLimitEn = !outputLimitOff_r;

  // Watermark comparison
  always_comb begin
    threshold    = {wmHigh_r, wmLow_r};
    thrNonZero   = (threshold != 10'h000);
    countAtLevel = (fifoCount >= {6'h00, threshold});
    wmCondition  = thrNonZero && countAtLevel &&
                   !fifoBurstActive;
    // Data reads with the FIFO disabled are not FIFO accesses
    dataRead     = fifoDataRead && fifoEnable_r;
  end

  // Burst tracker: marks which data read is the first of a burst
  always_comb begin
    rdState_nxt = rdState_r;
    unique case (rdState_r)
      RD_IDLE: begin
        // A read on the very first burst cycle is already the first read
        if (fifoBurstActive && dataRead) begin
          rdState_nxt = RD_REST;
        end else if (fifoBurstActive) begin
          rdState_nxt = RD_FIRST;
        end
      end
      RD_FIRST: begin
        if (!fifoBurstActive) begin
          rdState_nxt = RD_IDLE;
        end else if (dataRead) begin
          rdState_nxt = RD_REST;
        end
      end
      RD_REST: begin
        if (!fifoBurstActive) begin
          rdState_nxt = RD_IDLE;
        end
      end
    endcase
    if (pathRst_r.fifoRst) begin
      rdState_nxt = RD_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdState_r <= RD_IDLE;
    end else begin
      rdState_r <= rdState_nxt;
    end
  end

  // A read outside a marked burst also counts as a first read
  assign firstRead = dataRead && (rdState_r != RD_REST);

  always_comb begin
    wmClear  = firstRead || pathRst_r.fifoRst;
    wmSet    = wmCondition;
    // A new event in the clearing cycle survives
    flag_nxt = (flag_r && !wmClear) || wmSet;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign watermarkStatusFlag = flag_r;

  // Setting needs no burst in flight, so a latched pin waits for burst end
  sfw_int_pin u_int_pin (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .flagSet   (flag_nxt && !flag_r),
    .flagLevel (flag_r),
    .latchMode (intLatchMode),
    .intPin    (watermarkIntPin)
  );

  // Read mux; reserved and self-clearing bits read as zero
  always_comb begin
    rdMux  = READ_ZERO;
    mapped = 1'b1;
    unique case (regAddr)
      ADDR_ST_X: begin
        rdMux = factoryCodes.x;
      end
      ADDR_ST_Y: begin
        rdMux = factoryCodes.y;
      end
      ADDR_ST_Z: begin
        rdMux = factoryCodes.z;
      end
      ADDR_WM_HIGH: begin
        rdMux[1:0] = wmHigh_r;
      end
      ADDR_WM_LOW: begin
        rdMux = wmLow_r;
      end
      ADDR_PATH_RST: begin
        rdMux = READ_ZERO;
      end
      ADDR_MOTION: begin
        rdMux[MOT_ENABLE_BIT]  = motionEnable_r;
        rdMux[MOT_COMPARE_BIT] = motionCompare_r;
        rdMux[MOT_LIMIT_BIT]   = outputLimitOff_r;
        rdMux[MOT_COMBINE_BIT] = axisCombine_r;
      end
      ADDR_HOST: begin
        rdMux[HOST_FIFO_EN_BIT] = fifoEnable_r;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Status reads have no side effect on the watermark flag
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_r <= READ_ZERO;
    end else if (regRdEn) begin
      rdData_r <= rdMux;
    end
  end

  assign regRdData = rdData_r;
  assign regHit    = mapped;

endmodule

/* File: sim/sfw_wm_properties.sv */
`timescale 1ns/1ps
module sfw_wm_checker
  import sfw_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Register port
  input wire logic [7:0]  regAddr,
  input wire logic        regWrEn,
  input wire logic [7:0]  regWrData,
  input wire logic        regRdEn,
  input wire logic [7:0]  regRdData,
  input wire logic        regHit,
  // Factory codes
  input wire logic        otpLoad,
  input wire sfw_codes_t  otpCodes,
  // FIFO side
  input wire logic [15:0] fifoCount,
  input wire logic        fifoBurstActive,
  input wire logic        fifoDataRead,
  input wire logic        intLatchMode,
  // Outputs
  input wire logic        watermarkStatusFlag,
  input wire logic        watermarkIntPin,
  input wire sfw_cfg_t    cfg,
  input wire logic        outputLimitEn,
  input wire sfw_rst_t    pathRst,
  input wire sfw_codes_t  factoryCodes
);
  logic [9:0] thr_r;
  logic       readSeen_r;
  logic       wmCond;

  // Shadow of the threshold, so the trigger can be judged from the ports
  assign wmCond = (thr_r != 10'h000) && (fifoCount >= {6'h00, thr_r})
                  && !fifoBurstActive;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      thr_r <= 10'h000;
    end else if (regWrEn && regAddr == ADDR_WM_HIGH) begin
      thr_r[9:8] <= regWrData[1:0];
    end else if (regWrEn && regAddr == ADDR_WM_LOW) begin
      thr_r[7:0] <= regWrData;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      readSeen_r <= 1'b0;
    end else if (!fifoBurstActive) begin
      readSeen_r <= 1'b0;
    end else if (fifoDataRead && cfg.fifoEnable) begin
      readSeen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_flag_sets: assert property (
    wmCond && !pathRst.fifoRst |=> watermarkStatusFlag)
    else $error("watermark flag not set");
  a_zero_quiet: assert property (
    thr_r == 10'h000 |=> !$rose(watermarkStatusFlag))
    else $error("flag rose with zero threshold");
  a_first_read: assert property (
    fifoDataRead && fifoBurstActive && cfg.fifoEnable && !readSeen_r
    |=> !watermarkStatusFlag)
    else $error("first read did not clear flag");
  a_latch_pin: assert property (
    intLatchMode && $past(intLatchMode)
    |-> watermarkIntPin == watermarkStatusFlag)
    else $error("latched pin differs from flag");
  a_pin_waits: assert property (
    intLatchMode && fifoBurstActive |=> !$rose(watermarkIntPin))
    else $error("latched pin rose during burst");
  a_pulse_pin: assert property (
    $rose(watermarkStatusFlag) && !intLatchMode
    |-> watermarkIntPin [*5] ##1 !watermarkIntPin)
    else $error("pulse width wrong");
  a_fifo_rst: assert property (
    regWrEn && regAddr == ADDR_HOST && regWrData[2]
    |=> pathRst.fifoRst ##1 !pathRst.fifoRst)
    else $error("fifo reset pulse wrong");
  a_path_rst: assert property (
    regWrEn && regAddr == ADDR_PATH_RST
    |=> pathRst.accelPathRst == $past(regWrData[1])
        && pathRst.tempPathRst == $past(regWrData[0])
        && !pathRst.sensorRegClear)
    else $error("path reset wrong");
  a_all_rst: assert property (
    regWrEn && regAddr == ADDR_HOST && regWrData[0]
    |=> pathRst[4:1] == 4'hF)
    else $error("full path reset missing");
  a_motion_cfg: assert property (
    regWrEn && regAddr == ADDR_MOTION
    |=> cfg[4:1] == {$past(regWrData[7:6]), $past(regWrData[1:0])}
        && outputLimitEn == !$past(regWrData[1]))
    else $error("motion control fields wrong");
  a_fifo_en: assert property (
    regWrEn && regAddr == ADDR_HOST
    |=> cfg.fifoEnable == $past(regWrData[6]))
    else $error("fifo enable wrong");
  a_codes_load: assert property (
    otpLoad |=> factoryCodes == $past(otpCodes))
    else $error("factory codes not loaded");

  c_latched: cover property (watermarkStatusFlag && intLatchMode);
  c_pulsed: cover property ($rose(watermarkIntPin) && !intLatchMode);
  c_clear: cover property (fifoDataRead && cfg.fifoEnable);
endmodule

bind sfw_wm_ctrl_regs sfw_wm_checker u_chk (.ref_clk, .rst_b, .regAddr,
  .regWrEn, .regWrData, .regRdEn, .regRdData, .regHit, .otpLoad, .otpCodes,
  .fifoCount, .fifoBurstActive, .fifoDataRead, .intLatchMode,
  .watermarkStatusFlag, .watermarkIntPin, .cfg, .outputLimitEn, .pathRst,
  .factoryCodes);

/* File: sim/sfw_host_model.sv */
`timescale 1ns/1ps
module sfw_host_model
  import sfw_pkg::*;
(
  // Clock
  input  wire logic ref_clk,
  // Register requests
  output logic [7:0] regAddr,
  output logic       regWrEn,
  output logic [7:0] regWrData,
  output logic       regRdEn
);
  initial begin
    regAddr = 8'hA5;
    regWrEn = 1'b0;
    regWrData = 8'h5A;
    regRdEn = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    regAddr = a;
    // This host never selects the forbidden compare mode
    regWrData = (a == ADDR_MOTION) ? (d | 8'h40) : d;
    regWrEn = 1'b1;
    @(posedge ref_clk);
    #1;
    regWrEn = 1'b0;
    // Released lines show the inverse, never a stale value
    regAddr = ~a;
    regWrData = ~regWrData;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    #1;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge ref_clk);
    #1;
    regRdEn = 1'b0;
    regAddr = ~a;
  endtask
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench
  import sfw_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  regAddr, regWrData, regRdData;
  logic        regWrEn, regRdEn, regHit;
  logic        otpLoad, fifoBurstActive, fifoDataRead, intLatchMode;
  logic [15:0] fifoCount;
  sfw_codes_t  otpCodes, factoryCodes, codes;
  logic        watermarkStatusFlag, watermarkIntPin, outputLimitEn;
  sfw_cfg_t    cfg;
  sfw_rst_t    pathRst;
  logic [7:0]  expQ[$];
  logic        rdPend = 1'b0;
  logic [31:0] r;
  int          n_fail = 0;
  int          checks_done = 0;
  int          seed = 30;
  int          cyc = 0;
  logic [7:0]  addrs[9] = '{ADDR_ST_X, ADDR_ST_Y, ADDR_ST_Z, ADDR_WM_HIGH,
    ADDR_WM_LOW, ADDR_PATH_RST, ADDR_MOTION, ADDR_HOST, 8'h00};

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  sfw_wm_ctrl_regs DUT (.ref_clk, .rst_b, .regAddr, .regWrEn, .regWrData,
    .regRdEn, .regRdData, .regHit, .otpLoad, .otpCodes, .fifoCount,
    .fifoBurstActive, .fifoDataRead, .intLatchMode, .watermarkStatusFlag,
    .watermarkIntPin, .cfg, .outputLimitEn, .pathRst, .factoryCodes);

  sfw_host_model host (.ref_clk, .regAddr, .regWrEn, .regWrData, .regRdEn);

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask

  task automatic pulse_rd();
    tick(1);
    fifoDataRead = 1'b1;
    tick(1);
    fifoDataRead = 1'b0;
    tick(1);
  endtask

  task automatic flag_pin(input logic f, input logic p);
    check({23'h000000, watermarkStatusFlag}, {23'h000000, f});
    check({23'h000000, watermarkIntPin}, {23'h000000, p});
  endtask

  // Read data is judged one edge after the strobe was taken
  always @(posedge ref_clk) begin
    cyc++;
    if (rdPend) begin
      check({16'h0000, regRdData}, {16'h0000, expQ.pop_front()});
    end
    if (regRdEn) begin
      check({23'h000000, regHit}, {23'h000000, regAddr inside {ADDR_ST_X,
        ADDR_ST_Y, ADDR_ST_Z, ADDR_WM_HIGH, ADDR_WM_LOW, ADDR_PATH_RST,
        ADDR_MOTION, ADDR_HOST}});
    end
    rdPend <= regRdEn;
    if (cyc > 5000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    otpLoad = 1'b0;
    otpCodes = 24'h000000;
    fifoCount = 16'h0000;
    fifoBurstActive = 1'b0;
    fifoDataRead = 1'b0;
    intLatchMode = 1'b1;
    repeat (16) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    host.wr(8'h1A, 8'h00);
    rd(8'h1A, 8'h00);
    r = $random(seed);
    codes = r[23:0];
    otpCodes = codes;
    otpLoad = 1'b1;
    tick(1);
    otpLoad = 1'b0;
    rd(ADDR_ST_X, codes.x);
    rd(ADDR_ST_Y, codes.y);
    rd(ADDR_ST_Z, codes.z);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      host.wr(ADDR_WM_HIGH, r[7:0]);
      rd(ADDR_WM_HIGH, r[7:0] & 8'h03);
      host.wr(ADDR_WM_LOW, r[15:8]);
      rd(ADDR_WM_LOW, r[15:8]);
      host.wr(ADDR_MOTION, r[23:16]);
      rd(ADDR_MOTION, (r[23:16] | 8'h40) & 8'hC3);
      host.wr(ADDR_HOST, r[31:24] & 8'hFA);
      rd(ADDR_HOST, r[31:24] & 8'h40);
    end
    host.wr(ADDR_PATH_RST, 8'hFF);
    rd(ADDR_PATH_RST, 8'h00);
    host.wr(ADDR_HOST, 8'h01);
    rd(ADDR_HOST, 8'h00);
    host.wr(ADDR_WM_HIGH, 8'h00);
    host.wr(ADDR_WM_LOW, 8'h00);
    fifoCount = 16'h0200;
    tick(4);
    flag_pin(1'b0, 1'b0);
    host.wr(ADDR_WM_HIGH, 8'h03);
    host.wr(ADDR_WM_LOW, 8'hFF);
    fifoCount = 16'h03FE;
    tick(4);
    flag_pin(1'b0, 1'b0);
    fifoCount = 16'h03FF;
    tick(3);
    flag_pin(1'b1, 1'b1);
    host.wr(ADDR_HOST, 8'h00);
    fifoBurstActive = 1'b1;
    pulse_rd();
    flag_pin(1'b1, 1'b1);
    fifoBurstActive = 1'b0;
    host.wr(ADDR_HOST, 8'h40);
    fifoBurstActive = 1'b1;
    pulse_rd();
    flag_pin(1'b0, 1'b0);
    pulse_rd();
    flag_pin(1'b0, 1'b0);
    fifoBurstActive = 1'b0;
    tick(3);
    flag_pin(1'b1, 1'b1);
    intLatchMode = 1'b0;
    fifoCount = 16'h0000;
    fifoBurstActive = 1'b1;
    pulse_rd();
    fifoBurstActive = 1'b0;
    host.wr(ADDR_HOST, 8'h44);
    tick(3);
    flag_pin(1'b0, 1'b0);
    fifoCount = 16'h0400;
    tick(3);
    flag_pin(1'b1, 1'b1);
    tick(5);
    flag_pin(1'b1, 1'b0);
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    flag_pin(1'b0, 1'b0);
    rd(ADDR_WM_HIGH, 8'h00);
    rd(ADDR_WM_LOW, 8'h00);
    tick(3);
    close_out();
  end
endmodule
